/* uig_defines.svh */
/*
 * Register offsets, field positions, reset values and interrupt codes
 * of the serial port interrupt and baud block.
 * Assumes inclusion by bare name from the core module.
 */
`ifndef UIG_DEFINES_SVH
`define UIG_DEFINES_SVH
`define UIG_ADDR_W 3
`define UIG_OFF_IDENT 3'h0
`define UIG_OFF_ENABLE 3'h1
`define UIG_OFF_DIV_LO 3'h2
`define UIG_OFF_DIV_HI 3'h3
`define UIG_OFF_SCRATCH 3'h4
`define UIG_OFF_PORT_CFG 3'h5
`define UIG_RST_ENABLE 4'h0
`define UIG_RST_DIV 16'h0000
`define UIG_RST_SCRATCH 8'h00
`define UIG_RST_PORT_CFG 6'h00
`define UIG_CFG_FIFO_BIT 0
`define UIG_CFG_IRQ_OE_BIT 1
`define UIG_CFG_PRE_LSB 2
`define UIG_CFG_HS_LSB 4
`define UIG_HS_ON 2'h3
`define UIG_EN_RX_BIT 0
`define UIG_EN_TX_BIT 1
`define UIG_EN_LINE_BIT 2
`define UIG_EN_MODEM_BIT 3
`define UIG_CODE_NONE 4'h1
`define UIG_CODE_LINE 4'h6
`define UIG_CODE_RX 4'h4
`define UIG_CODE_TIMEOUT 4'hC
`define UIG_CODE_TX 4'h2
`define UIG_CODE_MODEM 4'h0
`define UIG_FIFO_TOP 2'h3
`define UIG_PRE_MOD 5'h0D
`define UIG_STEP_13 5'h01
`define UIG_STEP_1P625 5'h08
`define UIG_STEP_1 5'h0D
`endif

/* uig_pkg.sv */
/*
 * Types of the serial port interrupt and baud block.
 * Assumes uig_defines.svh is on the include path.
 */
package uig_pkg;
	typedef enum logic [1:0] {
		UIG_PRE_13 = 2'b00,
		UIG_PRE_1P625 = 2'b01,
		UIG_PRE_1 = 2'b10
	} uig_prescale_t;
	typedef enum logic [2:0] {
		UIG_SRC_NONE = 3'b000,
		UIG_SRC_LINE = 3'b001,
		UIG_SRC_RX = 3'b010,
		UIG_SRC_TIMEOUT = 3'b011,
		UIG_SRC_TX = 3'b100,
		UIG_SRC_MODEM = 3'b101
	} uig_src_t;
endpackage

/* uig_core.sv */
/*
 * Interrupt identification, per-source enables, baud generator and scratch
 * register of one serial port.
 * Assumes all status inputs come from logic on core_clk (no synchronisers)
 * and that core_clk is the reference clock of the baud generator.
 */
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/10ps
`include "uig_defines.svh"

// Operation
// - Identification bits 7:6 read ones in FIFO mode, zeros otherwise.
// - Identification bits 5:4 always read zero.
// - Bit 3 zero outside FIFO mode; timeout sets bits 3 and 2.
// - Bit 0 is one with nothing pending, zero when anything pends.
// - Code 0110, top priority, reports receive errors; cleared by line status read.
// - Code 0100 reports receive data or FIFO level; cleared by buffer reads.
// - Code 1100 reports FIFO timeout after four idle characters; cleared by read.
// - Code 0010 reports empty transmit buffer; cleared by write or identification read.
// - Code 0000 reports handshake change flags; cleared by handshake status read.
// - Enable register bits 7:4 always read zero.
// - Enable bit 3 gates handshake, bit 2 gates line status interrupt.
// - Enable bit 1 gates transmit empty, bit 0 gates receive ready.
// - All four enables clear means the interrupt never asserts.
// - Normal speed: reference pre-divided, then divided by 16-bit divisor 1..65535.
// - Generator output is the sixteen-times tick for transmitter and receiver.
// - High-speed selection divides the undivided reference by the same divisor.
// - Configuration selects pre-divider 13, 1.625 or 1.0.
// - Eight-bit scratch register, freely written and read, no side effect.
// - Interrupt output reaches the system only while its output enable is one.
// - FIFO control bit 0 selects FIFO mode, else single-buffer mode.
module uig_core (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [`UIG_ADDR_W-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic overrun_flag,
	input wire logic parity_error_flag,
	input wire logic missing_stop_flag,
	input wire logic break_detect_flag,
	input wire logic rx_data_ready,
	input wire logic rx_fifo_at_level,
	input wire logic rx_fifo_timeout,
	input wire logic tx_holding_empty,
	input wire logic tx_holding_write,
	input wire logic clear_to_send_changed,
	input wire logic set_ready_changed,
	input wire logic ring_trailing_edge,
	input wire logic carrier_detect_changed,
	output logic fifo_mode,
	output logic port_irq,
	output logic baud16_tick
);
	logic [3:0] enable_r;
	logic [15:0] divisor_r;
	logic [7:0] scratch_r;
	logic [5:0] port_cfg_r;
	logic tx_pend_r;
	logic tx_empty_d_r;
	logic [4:0] pre_acc_r;
	logic [4:0] pre_sum;
	logic [4:0] pre_step;
	logic pre_tick;
	logic high_speed;
	logic [15:0] div_cnt_r;
	logic [15:0] div_last;
	logic line_src;
	logic rx_src;
	logic timeout_src;
	logic modem_src;
	uig_pkg::uig_src_t src;
	uig_pkg::uig_prescale_t pre_sel;
	logic [3:0] id_code;
	logic [7:0] ident;
	logic wr_enable;
	logic wr_div_lo;
	logic wr_div_hi;
	logic wr_scratch;
	logic wr_port_cfg;
	logic rd_ident;
	logic [7:0] rd_nxt;
	logic irq_nxt;

	// Offset 0 is read only, so it has no write decode
	// Each decode lasts one cycle, since the bus never stretches a strobe
	assign wr_enable = reg_wr && (reg_addr == `UIG_OFF_ENABLE);
	assign wr_div_lo = reg_wr && (reg_addr == `UIG_OFF_DIV_LO);
	assign wr_div_hi = reg_wr && (reg_addr == `UIG_OFF_DIV_HI);
	assign wr_scratch = reg_wr && (reg_addr == `UIG_OFF_SCRATCH);
	assign wr_port_cfg = reg_wr && (reg_addr == `UIG_OFF_PORT_CFG);
	assign rd_ident = reg_rd && (reg_addr == `UIG_OFF_IDENT);

	// FIFO mode swaps single-buffer data ready for the level and timeout sources
	assign fifo_mode = port_cfg_r[`UIG_CFG_FIFO_BIT];
	assign high_speed = (port_cfg_r[`UIG_CFG_HS_LSB +: 2] == `UIG_HS_ON);
	// Pre-divider code 11 is unassigned and falls back to divide by 13
	assign pre_sel = uig_pkg::uig_prescale_t'(port_cfg_r[`UIG_CFG_PRE_LSB +: 2]);

	// Per-source enable bits, only four are implemented
	// Upper bits of a write are dropped and read back as zero
	always_ff @(posedge core_clk) begin
		if (rst) begin
			enable_r <= `UIG_RST_ENABLE;
		end else if (wr_enable) begin
			enable_r <= reg_wdata[3:0];
		end
	end

	// Bytes load independently, so the generator runs at a mixed rate between
	// the two writes; software must not rely on ticks until both are written
	always_ff @(posedge core_clk) begin
		if (rst) begin
			divisor_r <= `UIG_RST_DIV;
		end else begin
			if (wr_div_lo) begin
				divisor_r[7:0] <= reg_wdata;
			end
			if (wr_div_hi) begin
				divisor_r[15:8] <= reg_wdata;
			end
		end
	end

	// Nothing inside the port reads this value
	always_ff @(posedge core_clk) begin
		if (rst) begin
			scratch_r <= `UIG_RST_SCRATCH;
		end else if (wr_scratch) begin
			scratch_r <= reg_wdata;
		end
	end

	// Bit 0 FIFO mode, bit 1 interrupt output enable, bits 3:2 pre-divider,
	// bits 5:4 high speed when both are set
	// The two unused upper bits read back as zero
	always_ff @(posedge core_clk) begin
		if (rst) begin
			port_cfg_r <= `UIG_RST_PORT_CFG;
		end else if (wr_port_cfg) begin
			port_cfg_r <= reg_wdata[5:0];
		end
	end

	// Source conditions, each gated by its enable bit
	// Every flag except transmit empty is cleared by the logic that owns it, on its own register read
	assign line_src = enable_r[`UIG_EN_LINE_BIT] && (overrun_flag || parity_error_flag ||
		missing_stop_flag || break_detect_flag);
	assign rx_src = enable_r[`UIG_EN_RX_BIT] &&
		(fifo_mode ? rx_fifo_at_level : rx_data_ready);
	// Timeout exists only in FIFO mode, so bit 3 stays zero outside it
	assign timeout_src = enable_r[`UIG_EN_RX_BIT] && fifo_mode && rx_fifo_timeout;
	assign modem_src = enable_r[`UIG_EN_MODEM_BIT] && (clear_to_send_changed ||
		set_ready_changed || ring_trailing_edge || carrier_detect_changed);

	// The empty condition is a level that stays true until a write, so it is
	// latched on its rising edge: an identification read can then retire it
	// without waiting for new data.
	// Reset to one: an empty buffer straight after reset raises nothing.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			tx_empty_d_r <= 1'b1;
		end else begin
			tx_empty_d_r <= tx_holding_empty;
		end
	end

	// Set wins over both clears, so an empty edge in the cycle of a transmit
	// write or an identification read is never lost
	always_ff @(posedge core_clk) begin
		if (rst) begin
			tx_pend_r <= 1'b0;
		end else if (tx_holding_empty && !tx_empty_d_r) begin
			tx_pend_r <= 1'b1;
		end else if (tx_holding_write) begin
			tx_pend_r <= 1'b0;
		end else if (rd_ident && (src == uig_pkg::UIG_SRC_TX)) begin
			tx_pend_r <= 1'b0;
		end
	end

	// Fixed priority: line status, receive, transmit empty, handshake
	// Within the second level the timeout ranks above data ready
	always_comb begin
		if (line_src) begin
			src = uig_pkg::UIG_SRC_LINE;
		end else if (timeout_src) begin
			src = uig_pkg::UIG_SRC_TIMEOUT;
		end else if (rx_src) begin
			src = uig_pkg::UIG_SRC_RX;
		end else if (enable_r[`UIG_EN_TX_BIT] && tx_pend_r) begin
			src = uig_pkg::UIG_SRC_TX;
		end else if (modem_src) begin
			src = uig_pkg::UIG_SRC_MODEM;
		end else begin
			src = uig_pkg::UIG_SRC_NONE;
		end
	end

	// Low nibble of the identification value for the reported source
	always_comb begin
		case (src)
			uig_pkg::UIG_SRC_LINE: begin
				id_code = `UIG_CODE_LINE;
			end
			uig_pkg::UIG_SRC_RX: begin
				id_code = `UIG_CODE_RX;
			end
			uig_pkg::UIG_SRC_TIMEOUT: begin
				id_code = `UIG_CODE_TIMEOUT;
			end
			uig_pkg::UIG_SRC_TX: begin
				id_code = `UIG_CODE_TX;
			end
			uig_pkg::UIG_SRC_MODEM: begin
				id_code = `UIG_CODE_MODEM;
			end
			default: begin
				id_code = `UIG_CODE_NONE;
			end
		endcase
	end

	// Top two bits mirror FIFO mode
	assign ident = {(fifo_mode ? `UIG_FIFO_TOP : 2'h0), 2'h0, id_code};

	// Read data stand for one cycle only; unmapped offsets read zero
	// Reads have no side effect except the transmit-empty retire on offset 0
	always_comb begin
		rd_nxt = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				`UIG_OFF_IDENT: begin
					rd_nxt = ident;
				end
				`UIG_OFF_ENABLE: begin
					rd_nxt = {4'h0, enable_r};
				end
				`UIG_OFF_DIV_LO: begin
					rd_nxt = divisor_r[7:0];
				end
				`UIG_OFF_DIV_HI: begin
					rd_nxt = divisor_r[15:8];
				end
				`UIG_OFF_SCRATCH: begin
					rd_nxt = scratch_r;
				end
				`UIG_OFF_PORT_CFG: begin
					rd_nxt = {2'h0, port_cfg_r};
				end
				default: begin
					rd_nxt = 8'h00;
				end
			endcase
		end
	end

	// Registered so read data appear exactly one cycle after the strobe
	always_ff @(posedge core_clk) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= rd_nxt;
		end
	end

	// The pin is registered: sources and enables may change in one cycle,
	// and a combinational output could glitch the system interrupt line
	assign irq_nxt = (src != uig_pkg::UIG_SRC_NONE) && port_cfg_r[`UIG_CFG_IRQ_OE_BIT];

	// Output enable clear holds the pin low but leaves the identification live
	always_ff @(posedge core_clk) begin
		if (rst) begin
			port_irq <= 1'b0;
		end else begin
			port_irq <= irq_nxt;
		end
	end

	// Fractional pre-divider: 1.625 is 13/8, so the accumulator adds 8 per
	// cycle modulo 13; ticks jitter by one cycle but average exactly.
	always_comb begin
		case (pre_sel)
			uig_pkg::UIG_PRE_1P625: begin
				pre_step = `UIG_STEP_1P625;
			end
			uig_pkg::UIG_PRE_1: begin
				pre_step = `UIG_STEP_1;
			end
			default: begin
				pre_step = `UIG_STEP_13;
			end
		endcase
	end

	// High speed bypasses the pre-divider: every reference cycle feeds the divisor
	assign pre_sum = pre_acc_r + pre_step;
	assign pre_tick = high_speed || (pre_sum >= `UIG_PRE_MOD);

	// Remainder stays below 13, so the sum never needs more than five bits
	always_ff @(posedge core_clk) begin
		if (rst) begin
			pre_acc_r <= 5'h00;
		end else if (high_speed) begin
			pre_acc_r <= 5'h00;
		end else if (pre_sum >= `UIG_PRE_MOD) begin
			pre_acc_r <= pre_sum - `UIG_PRE_MOD;
		end else begin
			pre_acc_r <= pre_sum;
		end
	end

	// A zero divisor is outside the legal range and halts the generator
	// Divisor 1 ticks on every pre-divider tick, the fastest rate there is
	assign div_last = divisor_r - 16'h0001;

	// The count compares with >= so that a divisor made smaller mid-count
	// wraps at once instead of running through every count value
	always_ff @(posedge core_clk) begin
		if (rst) begin
			div_cnt_r <= 16'h0000;
		end else if (divisor_r == 16'h0000) begin
			div_cnt_r <= 16'h0000;
		end else if (pre_tick) begin
			if (div_cnt_r >= div_last) begin
				div_cnt_r <= 16'h0000;
			end else begin
				div_cnt_r <= div_cnt_r + 16'h0001;
			end
		end
	end

	// Tick leaves a flip-flop one cycle after the terminal count, one cycle wide
	always_ff @(posedge core_clk) begin
		if (rst) begin
			baud16_tick <= 1'b0;
		end else begin
			baud16_tick <= pre_tick && (divisor_r != 16'h0000) && (div_cnt_r >= div_last);
		end
	end
endmodule

/* uig_props.sv */
/* Port checker of the interrupt and baud block. Assumes it is bound to uig_core. */
`timescale 1ns/10ps
module uig_props (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic fifo_mode,
	input wire logic port_irq
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	a_ident_top: assert property (reg_rd && reg_addr == 3'h0 |=> reg_rdata[7:6] == {2{fifo_mode}})
		else $error("identification top bits wrong");
	a_ident_zero: assert property (reg_rd && reg_addr == 3'h0 |=> reg_rdata[5:4] == 2'h0)
		else $error("identification bits 5:4 not zero");
	a_ident_bit3: assert property (reg_rd && reg_addr == 3'h0 && !fifo_mode |=> !reg_rdata[3])
		else $error("timeout bit set outside fifo mode");
	a_ident_pending: assert property (reg_rd && reg_addr == 3'h0 |=> !(port_irq && reg_rdata[0]))
		else $error("no-pending bit set while interrupt asserted");
	a_enable_top: assert property (reg_rd && reg_addr == 3'h1 |=> reg_rdata[7:4] == 4'h0)
		else $error("enable upper bits not zero");
	a_enable_off: assert property (reg_wr && reg_addr == 3'h1 && reg_wdata[3:0] == 4'h0 |=> ##1 !port_irq)
		else $error("interrupt with all enables clear");
	a_irq_gate: assert property (reg_wr && reg_addr == 3'h5 && !reg_wdata[1] |=> ##1 !port_irq)
		else $error("interrupt with output enable clear");
	a_fifo_sel: assert property (reg_wr && reg_addr == 3'h5 |=> fifo_mode == $past(reg_wdata[0]))
		else $error("fifo mode does not follow control bit");
endmodule
bind uig_core uig_props u_props (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fifo_mode(fifo_mode), .port_irq(port_irq));

/* uig_host.sv */
/* Host model driving the register port. Assumes callers issue one access at a time. */
`timescale 1ns/10ps
module uig_host (
	input wire logic core_clk,
	output logic [2:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata
);
	initial begin
		reg_addr = 3'h7;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// Released lines show inverted leftovers so a stale value never looks valid
	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~v;
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] v);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1;
		v = reg_rdata;
	endtask
endmodule

/* uig_core_bench.sv */
/* Self-checking bench of uig_core. Assumes uig_host and the bound checker are compiled. */
`timescale 1ns/10ps
module uig_core_bench;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [12:0] src = 13'h0000;
	logic [2:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, d;
	logic reg_wr, reg_rd, fifo_mode, port_irq, baud16_tick;
	logic [31:0] seed = 32'd54979;
	logic [7:0] en[4] = '{8'h04, 8'h01, 8'h08, 8'h00};
	logic [7:0] id[4] = '{8'h06, 8'h04, 8'h00, 8'h01};
	logic [7:0] cf[5] = '{8'h08, 8'h00, 8'h04, 8'h30, 8'h0C};
	logic [7:0] dv[5] = '{8'h01, 8'h02, 8'h01, 8'h03, 8'h01};
	int failures = 0;
	int n_compared = 0;
	always #50 core_clk = ~core_clk;
	uig_host u_host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata));
	uig_core u_dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .overrun_flag(src[0]), .parity_error_flag(src[1]),
		.missing_stop_flag(src[2]), .break_detect_flag(src[3]), .rx_data_ready(src[4]), .rx_fifo_at_level(src[5]),
		.rx_fifo_timeout(src[6]), .tx_holding_empty(src[7]), .tx_holding_write(src[8]),
		.clear_to_send_changed(src[9]), .set_ready_changed(src[10]), .ring_trailing_edge(src[11]),
		.carrier_detect_changed(src[12]), .fifo_mode(fifo_mode), .port_irq(port_irq), .baud16_tick(baud16_tick));
	function logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	// Cycles spanned by eight ticks: eight times divisor times pre-divider
	function logic [7:0] gap_exp(input logic [7:0] cfg, input logic [7:0] div);
		if (cfg[5:4] == 2'h3 || cfg[3:2] == 2'h2) return 8'(8 * div);
		if (cfg[3:2] == 2'h1) return 8'(13 * div);
		return 8'(104 * div);
	endfunction
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task rdc(input logic [2:0] a, input logic [7:0] e);
		u_host.rd(a, d);
		chk(d, e);
	endtask
	// Three edges cover the sample, latch and output stages of the interrupt path
	task put(input logic [12:0] v);
		@(posedge core_clk);
		src <= v;
		repeat (3) @(posedge core_clk);
		#1;
	endtask
	task gap(output int c);
		int i;
		i = 0;
		c = 0;
		do begin
			@(posedge core_clk);
			#1;
		end while (baud16_tick !== 1'b1);
		while (i < 8) begin
			@(posedge core_clk);
			#1;
			c++;
			if (baud16_tick === 1'b1) i++;
		end
	endtask
	task results();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		#1_000_000;
		failures++;
		results();
	end
	initial begin
		int k;
		int c;
		logic [7:0] v;
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		for (k = 1; k < 8; k++) rdc(k[2:0], 8'h00);
		repeat (4) begin
			v = rnd();
			u_host.wr(3'h4, v);
			rdc(3'h4, v);
			u_host.wr(3'h1, ~v);
			rdc(3'h1, {4'h0, ~v[3:0]});
			u_host.wr(3'h2, v);
			rdc(3'h2, v);
		end
		u_host.wr(3'h0, 8'hFF);
		rdc(3'h0, 8'h01);
		u_host.wr(3'h5, 8'h02);
		put(13'h1E1F);
		for (k = 0; k < 4; k++) begin
			u_host.wr(3'h1, en[k]);
			repeat (3) @(posedge core_clk);
			#1;
			chk({7'h0, port_irq}, {7'h0, en[k] != 8'h00});
			rdc(3'h0, id[k]);
		end
		u_host.wr(3'h1, 8'h0F);
		u_host.wr(3'h5, 8'h00);
		repeat (3) @(posedge core_clk);
		#1;
		chk({7'h0, port_irq}, 8'h00);
		rdc(3'h0, 8'h06);
		u_host.wr(3'h5, 8'h03);
		put(13'h1EEF);
		rdc(3'h0, 8'hC6);
		chk({7'h0, port_irq}, 8'h01);
		put(13'h1EE0);
		rdc(3'h0, 8'hCC);
		put(13'h1EA0);
		rdc(3'h0, 8'hC4);
		put(13'h1E80);
		rdc(3'h0, 8'hC2);
		chk({7'h0, port_irq}, 8'h01);
		rdc(3'h0, 8'hC0);
		put(13'h0000);
		put(13'h0080);
		chk({7'h0, port_irq}, 8'h01);
		@(posedge core_clk);
		src[8] <= 1'b1;
		@(posedge core_clk);
		src[8] <= 1'b0;
		rdc(3'h0, 8'hC1);
		chk({7'h0, port_irq}, 8'h00);
		put(13'h0000);
		rdc(3'h0, 8'hC1);
		chk({7'h0, port_irq}, 8'h00);
		for (k = 0; k < 5; k++) begin
			u_host.wr(3'h5, cf[k]);
			u_host.wr(3'h2, dv[k]);
			u_host.wr(3'h3, 8'h00);
			gap(c);
			gap(c);
			chk(c[7:0], gap_exp(cf[k], dv[k]));
		end
		results();
	end
endmodule
